// ===== design/comparator_map.svh
// Register offsets, field positions, reset values and timing counts of the comparator.
`ifndef COMPARATOR_MAP_SVH
`define COMPARATOR_MAP_SVH

// Register indices; the byte address is four times the index.
`define CMP_IDX_CONTROL    3'h0
`define CMP_IDX_MUX        3'h2
`define CMP_IDX_IRQ_ENABLE 3'h6
`define CMP_IDX_STATUS     3'h7

// Control register fields.
`define CMP_CTRL_ENABLE    0
`define CMP_CTRL_HYST_LO   1
`define CMP_CTRL_HYST_HI   2
`define CMP_CTRL_LOWCUR    3
`define CMP_CTRL_EDGE_LO   4
`define CMP_CTRL_EDGE_HI   5
`define CMP_CTRL_PADEN     6
`define CMP_CTRL_STDBYRUN  7

// Multiplexer register fields.
`define CMP_MUX_NEG_LO     0
`define CMP_MUX_NEG_HI     1
`define CMP_MUX_INVERT     7

// Interrupt enable and status fields.
`define CMP_IRQ_BIT        0
`define CMP_STAT_STATE     4

// Reset values.
`define CMP_CONTROL_RESET  8'h00
`define CMP_MUX_RESET      8'h00
`define CMP_IRQEN_RESET    8'h00

// Bus answers.
`define CMP_RESP_OKAY      2'h0
`define CMP_RESP_SLVERR    2'h2

// Start-up times in nanoseconds and the clock rate in hertz.
`define CMP_CORE_START_NS  2500
`define CMP_VREF_START_NS  60000
`define CMP_CLK_HZ         10000000
`define CMP_CLK_PERIOD_NS  (1000000000 / `CMP_CLK_HZ)
`define CMP_CORE_START_CYC ((`CMP_CORE_START_NS + `CMP_CLK_PERIOD_NS - 1) / `CMP_CLK_PERIOD_NS)
`define CMP_VREF_START_CYC ((`CMP_VREF_START_NS + `CMP_CLK_PERIOD_NS - 1) / `CMP_CLK_PERIOD_NS)

`endif

// ===== design/comparator_pkg.sv
// Types shared by the comparator control logic and its users.
package comparator_pkg;

  // Sleep state reported by the power manager.
  typedef enum logic [1:0] {
    SLEEP_ACTIVE  = 2'b00,
    SLEEP_IDLE    = 2'b01,
    SLEEP_STANDBY = 2'b10,
    SLEEP_PDOWN   = 2'b11
  } sleep_mode_t;

  // Result edges that set the interrupt flag.
  typedef enum logic [1:0] {
    EDGE_ANY     = 2'b00,
    EDGE_RSVD    = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_RISING  = 2'b11
  } irq_edge_select_t;

  // Negative input sources.
  typedef enum logic [1:0] {
    NEG_PIN_ZERO = 2'b00,
    NEG_RSVD     = 2'b01,
    NEG_VREF     = 2'b10,
    NEG_DAC      = 2'b11
  } negative_source_select_t;

endpackage

// ===== design/comparator_control_logic.sv
// Digital control of one voltage comparator with an AXI4-Lite register bank.
//
// Operation
// - Control bit 0 switches the comparator on; clear keeps it off.
// - Result invalid for 2.5us after enable, 60us when reference selected.
// - Edge field: 0 both edges, 2 falling, 3 rising, 1 reserved.
// - A selected result edge sets the interrupt flag in status.
// - Interrupt request is high while enable and flag are both set.
// - Interrupt enable register at index 6 (byte address 0x18) holds the interrupt enable bit.
// - Writing one to the status flag clears it; zero leaves it.
// - Status state bit shows the result through a 3-cycle synchroniser.
// - Invert bit 7 of mux control inverts the result for every consumer.
// - Negative select: 0 pin, 2 reference, 3 DAC, 1 reserved.
// - Control bit 6 drives the result onto the output pad.
// - Control bit 3 puts the core into low-current, slower operation.
// - Hysteresis field: 0 off, 1 10mV, 2 25mV, 3 50mV.
// - While enabled the result is given continuously as an event.
// - In idle sleep everything keeps working as in active mode.
// - Standby halts unless run bit set; then status frozen without clock.
// - Power-down disables comparator and pad regardless of configuration.
// - Debug halt does not change comparator operation.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "comparator_map.svh"

module comparator_control_logic #(
  parameter int ADDR_W = 5
) (
  input  wire logic                                    ref_clk,
  input  wire logic                                    rst,
  input  wire logic                                    clkEn,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0]                       s_axi_awaddr,
  input  wire logic                                    s_axi_awvalid,
  output logic                                         s_axi_awready,
  input  wire logic [31:0]                             s_axi_wdata,
  input  wire logic [3:0]                              s_axi_wstrb,
  input  wire logic                                    s_axi_wvalid,
  output logic                                         s_axi_wready,
  output logic [1:0]                                   s_axi_bresp,
  output logic                                         s_axi_bvalid,
  input  wire logic                                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]                       s_axi_araddr,
  input  wire logic                                    s_axi_arvalid,
  output logic                                         s_axi_arready,
  output logic [31:0]                                  s_axi_rdata,
  output logic [1:0]                                   s_axi_rresp,
  output logic                                         s_axi_rvalid,
  input  wire logic                                    s_axi_rready,
  // System state.
  input  wire comparator_pkg::sleep_mode_t             sleepMode,
  input  wire logic                                    perClkRequested,
  // Analog core.
  input  wire logic                                    coreResult,
  output logic                                         coreEnable,
  output logic                                         coreLowCurrent,
  output logic [1:0]                                   hysteresisSelect,
  output comparator_pkg::negative_source_select_t      negativeSourceSelect,
  output logic                                         positiveSourceSelect,
  output logic                                         vrefRequest,
  output logic                                         resultValid,
  // Consumers of the result.
  output logic                                         eventOut,
  output logic                                         padOut,
  output logic                                         padDriveEnable,
  output logic                                         irqOut
);
  import comparator_pkg::*;

  // Index of a register from a byte address.
  function automatic logic [2:0] regIndex(input logic [ADDR_W-1:0] addr);
    regIndex = addr[4:2];
  endfunction

  // True for indices that hold a register.
  function automatic logic isMapped(input logic [2:0] idx);
    isMapped = (idx == `CMP_IDX_CONTROL) || (idx == `CMP_IDX_MUX) ||
               (idx == `CMP_IDX_IRQ_ENABLE) || (idx == `CMP_IDX_STATUS);
  endfunction

  localparam logic [9:0] CoreStartCyc = 10'(`CMP_CORE_START_CYC);
  localparam logic [9:0] VrefStartCyc = 10'(`CMP_VREF_START_CYC);

  logic [7:0]        controlQ;
  logic [7:0]        muxQ;
  logic              irqEnableQ;
  logic              flagQ;
  logic              flagD;
  logic              awHeldQ;
  logic              wHeldQ;
  logic [2:0]        wIdxQ;
  logic [7:0]        wDataQ;
  logic              wLaneQ;
  logic              doWrite;
  logic              sync1Q;
  logic              sync2Q;
  logic              stateQ;
  logic              prevQ;
  logic              inverted;
  logic              coreOn;
  logic              statusRuns;
  logic              edgeHit;
  logic [9:0]        startCntQ;
  logic              validQ;
  irq_edge_select_t  edgeSel;

  // Sleep handling; debug halt has no input because it changes nothing.
  // Idle is treated exactly like active.
  always_comb begin
    coreOn = controlQ[`CMP_CTRL_ENABLE];
    case (sleepMode)
      SLEEP_ACTIVE:  coreOn = controlQ[`CMP_CTRL_ENABLE];
      SLEEP_IDLE:    coreOn = controlQ[`CMP_CTRL_ENABLE];
      SLEEP_STANDBY: coreOn = controlQ[`CMP_CTRL_ENABLE] &
                              controlQ[`CMP_CTRL_STDBYRUN];
      SLEEP_PDOWN:   coreOn = 1'b0;
      default:       coreOn = 1'b0;
    endcase
  end

  // Status and flag setting stop only in standby without a peripheral clock request.
  assign statusRuns = (sleepMode != SLEEP_STANDBY) | perClkRequested;

  assign edgeSel = irq_edge_select_t'(controlQ[`CMP_CTRL_EDGE_HI:`CMP_CTRL_EDGE_LO]);

  // Edge detection on the inverted, synchronised result.
  always_comb begin
    case (edgeSel)
      EDGE_ANY:     edgeHit = stateQ ^ prevQ;
      EDGE_FALLING: edgeHit = prevQ & ~stateQ;
      EDGE_RISING:  edgeHit = stateQ & ~prevQ;
      default:      edgeHit = 1'b0; // Reserved code sets nothing.
    endcase
  end

  // The set wins over a software clear in the same cycle.
  always_comb begin
    flagD = flagQ;
    if (doWrite && wLaneQ && (wIdxQ == `CMP_IDX_STATUS) && wDataQ[`CMP_IRQ_BIT]) begin
      flagD = 1'b0;
    end
    if (coreOn && validQ && statusRuns && edgeHit) begin
      flagD = 1'b1;
    end
  end

  // Synchroniser; the first stage feeds only the second.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1Q <= 1'b0;
      sync2Q <= 1'b0;
    end else if (clkEn) begin
      sync1Q <= coreResult;
      sync2Q <= sync1Q;
    end
  end

  // Inversion sits before every consumer.
  assign inverted = sync2Q ^ muxQ[`CMP_MUX_INVERT];

  // Third stage is the status state; it holds while the clock is withheld.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateQ <= 1'b0;
      prevQ  <= 1'b0;
    end else if (clkEn && statusRuns) begin
      stateQ <= inverted;
      prevQ  <= stateQ;
    end
  end

  // Start-up guard; the reference path needs far longer than the core.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      startCntQ <= 10'h000;
      validQ    <= 1'b0;
    end else if (clkEn) begin
      if (!coreOn) begin
        startCntQ <= 10'h000;
        validQ    <= 1'b0;
      end else if (!validQ) begin
        if (startCntQ >= ((negativeSourceSelect == NEG_VREF) ? VrefStartCyc : CoreStartCyc)
            - 10'h001) begin
          validQ <= 1'b1;
        end else begin
          startCntQ <= startCntQ + 10'h001;
        end
      end
    end
  end

  // Flag and request; the request follows the flag and the enable.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flagQ  <= 1'b0;
      irqOut <= 1'b0;
    end else if (clkEn) begin
      flagQ  <= flagD;
      irqOut <= flagD & irqEnableQ;
    end
  end

  // Core controls, pad and event; an invalid result is not passed on.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      coreEnable           <= 1'b0;
      coreLowCurrent       <= 1'b0;
      hysteresisSelect     <= 2'b00;
      negativeSourceSelect <= NEG_PIN_ZERO;
      positiveSourceSelect <= 1'b0;
      vrefRequest          <= 1'b0;
      resultValid          <= 1'b0;
      eventOut             <= 1'b0;
      padOut               <= 1'b0;
      padDriveEnable       <= 1'b0;
    end else if (clkEn) begin
      coreEnable           <= coreOn;
      coreLowCurrent       <= controlQ[`CMP_CTRL_LOWCUR];
      hysteresisSelect     <= controlQ[`CMP_CTRL_HYST_HI:`CMP_CTRL_HYST_LO];
      negativeSourceSelect <= negative_source_select_t'(
                                muxQ[`CMP_MUX_NEG_HI:`CMP_MUX_NEG_LO]);
      positiveSourceSelect <= 1'b0; // Only positive pin zero exists.
      vrefRequest          <= coreOn & (negativeSourceSelect == NEG_VREF);
      resultValid          <= validQ;
      eventOut             <= coreOn & validQ & inverted;
      padOut               <= coreOn & validQ & inverted;
      padDriveEnable       <= coreOn & controlQ[`CMP_CTRL_PADEN];
    end
  end

  // Write channel: address and data are taken in either order, then answered.
  assign doWrite = awHeldQ & wHeldQ & ~s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awHeldQ       <= 1'b0;
      wHeldQ        <= 1'b0;
      wIdxQ         <= 3'h0;
      wDataQ        <= 8'h00;
      wLaneQ        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CMP_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_awready <= ~awHeldQ & ~s_axi_bvalid & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~wHeldQ & ~s_axi_bvalid & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldQ <= 1'b1;
        wIdxQ   <= regIndex(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldQ <= 1'b1;
        wDataQ <= s_axi_wdata[7:0];
        wLaneQ <= s_axi_wstrb[0];
      end
      if (doWrite) begin
        awHeldQ      <= 1'b0;
        wHeldQ       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(wIdxQ) ? `CMP_RESP_OKAY : `CMP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Register storage; software is trusted to enable last.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      controlQ   <= `CMP_CONTROL_RESET;
      muxQ       <= `CMP_MUX_RESET;
      irqEnableQ <= 1'b0;
    end else if (clkEn && doWrite && wLaneQ) begin
      case (wIdxQ)
        `CMP_IDX_CONTROL:    controlQ   <= wDataQ;
        `CMP_IDX_MUX:        muxQ       <= wDataQ & 8'h83;
        `CMP_IDX_IRQ_ENABLE: irqEnableQ <= wDataQ[`CMP_IRQ_BIT];
        default:             irqEnableQ <= irqEnableQ;
      endcase
    end
  end

  // Read channel: one read at a time, answered one cycle after it is taken.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CMP_RESP_OKAY;
    end else if (clkEn) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= isMapped(regIndex(s_axi_araddr)) ? `CMP_RESP_OKAY
                                                         : `CMP_RESP_SLVERR;
        case (regIndex(s_axi_araddr))
          `CMP_IDX_CONTROL:    s_axi_rdata <= {24'h000000, controlQ};
          `CMP_IDX_MUX:        s_axi_rdata <= {24'h000000, muxQ};
          `CMP_IDX_IRQ_ENABLE: s_axi_rdata <= {31'h00000000, irqEnableQ};
          `CMP_IDX_STATUS:     s_axi_rdata <= {27'h0000000, stateQ, 3'h0, flagQ};
          default:             s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ===== bench/comparator_core_model.sv
// Behavioural model of the analog comparator core beside the control logic.
`timescale 1ns/1ns
module comparator_core_model (
  input  wire logic ref_clk,
  input  wire logic coreEnable,
  input  wire logic coreLowCurrent,
  input  wire logic plusAbove,
  output logic      coreResult
);
  logic [1:0] slow_q = 2'h0;
  logic       wander_q = 1'b0;

  // The slow copy stands for the longer reaction of the low-current core.
  always_ff @(posedge ref_clk) begin
    slow_q   <= {slow_q[0], plusAbove};
    wander_q <= ~wander_q;
  end

  // A core that is off has no defined output, so it wanders every cycle.
  assign coreResult = !coreEnable ? wander_q
                                  : (coreLowCurrent ? slow_q[1] : plusAbove);
endmodule

// ===== bench/comparator_control_logic_sva.sv
// Assertions on the ports of the comparator control logic.
`timescale 1ns/1ns
module comparator_control_logic_sva (
  input wire logic                                    ref_clk,
  input wire logic                                    rst,
  input wire comparator_pkg::sleep_mode_t             sleepMode,
  input wire logic                                    coreEnable,
  input wire logic                                    padDriveEnable,
  input wire logic                                    padOut,
  input wire logic                                    eventOut,
  input wire logic                                    resultValid,
  input wire logic                                    vrefRequest,
  input wire comparator_pkg::negative_source_select_t negativeSourceSelect,
  input wire logic                                    s_axi_arvalid,
  input wire logic                                    s_axi_arready,
  input wire logic                                    s_axi_rvalid
);
  import comparator_pkg::*;

  // All checks share one clock; reset silences them.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_pdown_off: assert property (sleepMode == SLEEP_PDOWN |=>
    !coreEnable && !padDriveEnable)
    else $error("core or pad on in power-down");
  chk_pad_needs_core: assert property (padDriveEnable |-> coreEnable)
    else $error("pad driven with core off");
  chk_pad_mirror: assert property (padOut == eventOut)
    else $error("pad differs from event");
  chk_event_idle: assert property (!coreEnable && !$past(coreEnable) |-> !eventOut)
    else $error("event high with core off");
  chk_valid_core: assert property (!coreEnable && !$past(coreEnable) |-> !resultValid)
    else $error("result valid with core off");
  chk_start_wait: assert property ($rose(coreEnable) |->
    !resultValid [*8] ##[14:700] resultValid)
    else $error("start-up time wrong");
  chk_vref_source: assert property (vrefRequest |->
    $past(negativeSourceSelect) == NEG_VREF)
    else $error("reference asked without its source");
  chk_read_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule

bind comparator_control_logic comparator_control_logic_sva chk_u (
  .ref_clk(ref_clk), .rst(rst), .sleepMode(sleepMode), .coreEnable(coreEnable),
  .padDriveEnable(padDriveEnable), .padOut(padOut), .eventOut(eventOut),
  .resultValid(resultValid), .vrefRequest(vrefRequest),
  .negativeSourceSelect(negativeSourceSelect), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ===== bench/comparator_control_logic_bench.sv
// Self-checking bench for the comparator control logic.
`timescale 1ns/1ns
`include "comparator_map.svh"
module comparator_control_logic_bench;
  import comparator_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, perClk = 1'b0, plusAbove = 1'b0, clkEn = 1'b1;
  logic [4:0]  awAddr = '0, arAddr = '0;
  logic [31:0] wData = '0, rData;
  logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic        awReady, wReady, bValid, arReady, rValid, coreRes, coreEn, lowCur;
  logic        vrefReq, resValid, eventOut, padOut, padEn, irqOut;
  logic [1:0]  bResp, rResp, hyst;
  sleep_mode_t sleepMode = SLEEP_ACTIVE;
  negative_source_select_t negSel;
  logic [33:0] expQ[$];
  int          miscompares = 0, testsRun = 0;

  always #50 ref_clk = ~ref_clk;

  comparator_control_logic dut_u (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .sleepMode(sleepMode), .perClkRequested(perClk), .coreResult(coreRes),
    .coreEnable(coreEn), .coreLowCurrent(lowCur), .hysteresisSelect(hyst),
    .negativeSourceSelect(negSel), .positiveSourceSelect(), .vrefRequest(vrefReq),
    .resultValid(resValid), .eventOut(eventOut), .padOut(padOut),
    .padDriveEnable(padEn), .irqOut(irqOut));

  comparator_core_model core_u (.ref_clk(ref_clk), .coreEnable(coreEn),
    .coreLowCurrent(lowCur), .plusAbove(plusAbove), .coreResult(coreRes));

  task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus answers are matched against the notes left by the bus tasks.
  always @(posedge ref_clk) begin
    if (bValid && bReady) chk("bresp", expQ.pop_front(), {bResp, 32'h0});
    if (rValid && rReady) chk("rdata", expQ.pop_front(), {rResp, rData});
  end

  // Address and data are offered together and each released when taken.
  task automatic wr(input logic [2:0] ix, input logic [7:0] d, input logic [1:0] rs = 2'h0);
    @(posedge ref_clk);
    expQ.push_back({rs, 32'h0});
    awAddr <= {ix, 2'b00};
    wData <= {24'h0, d};
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    bReady <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] ix, input logic [31:0] d, input logic [1:0] rs = 2'h0);
    @(posedge ref_clk);
    expQ.push_back({rs, d});
    arAddr <= {ix, 2'b00};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    rReady <= 1'b0;
  endtask

  // Sources are chosen before the enable, then the start-up time is counted.
  task automatic startup(input logic [1:0] neg, input int lo);
    int n = 0;
    wr(`CMP_IDX_CONTROL, 8'h00);
    wr(`CMP_IDX_MUX, {6'h0, neg});
    wr(`CMP_IDX_CONTROL, 8'h41);
    while (!resValid && n < 2000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("startup", 34'h1, 34'(n >= lo - 2 && n <= lo + 4));
    chk("vref", {33'h0, neg == NEG_VREF}, {33'h0, vrefReq});
    chk("pad", 34'h1, {33'h0, padEn});
  endtask

  task automatic edgeTry(input logic [1:0] m, input logic lvl);
    logic f;
    f = m == EDGE_ANY || (m == EDGE_RISING && lvl) || (m == EDGE_FALLING && !lvl);
    wr(`CMP_IDX_CONTROL, {2'b01, m, 4'h1});
    wr(`CMP_IDX_STATUS, 8'h01);
    plusAbove <= lvl;
    repeat (8) @(posedge ref_clk);
    chk("irq", {33'h0, f}, {33'h0, irqOut});
    rd(`CMP_IDX_STATUS, {27'h0, lvl, 3'h0, f});
    wr(`CMP_IDX_STATUS, 8'h00);
    rd(`CMP_IDX_STATUS, {27'h0, lvl, 3'h0, f});
    wr(`CMP_IDX_STATUS, 8'h01);
    rd(`CMP_IDX_STATUS, {27'h0, lvl, 4'h0});
    chk("irq", 34'h0, {33'h0, irqOut});
  endtask

  task automatic wrapUp();
    $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // A hang is cut off well after the whole sequence should have ended.
  initial begin
    #3000000;
    miscompares++;
    wrapUp();
  end

  initial begin
    logic [7:0] v;
    void'($urandom(32'he87588c3));
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`CMP_IDX_CONTROL, 32'h0);
    rd(`CMP_IDX_MUX, 32'h0);
    rd(`CMP_IDX_IRQ_ENABLE, 32'h0);
    rd(3'h1, 32'h0, `CMP_RESP_SLVERR);
    wr(3'h3, 8'h55, `CMP_RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      v = {4'h0, 1'($urandom), 2'(i), 1'b0};
      wr(`CMP_IDX_CONTROL, v);
      rd(`CMP_IDX_CONTROL, {24'h0, v});
      chk("hyst", 34'(i), {32'h0, hyst});
      chk("lowcur", {33'h0, v[3]}, {33'h0, lowCur});
      v = 8'($urandom) & 8'h83;
      wr(`CMP_IDX_MUX, v);
      rd(`CMP_IDX_MUX, {24'h0, v});
      chk("negsel", {32'h0, v[1:0]}, {32'h0, negSel});
    end
    $display("done: registers");
    startup(NEG_VREF, 600);
    startup(NEG_PIN_ZERO, 25);
    wr(`CMP_IDX_IRQ_ENABLE, 8'h01);
    for (int m = 0; m < 4; m++) begin
      edgeTry(2'(m), 1'b1);
      edgeTry(2'(m), 1'b0);
    end
    $display("done: edges");
    sleepMode <= SLEEP_IDLE;
    wr(`CMP_IDX_MUX, 8'h80);
    repeat (8) @(posedge ref_clk);
    rd(`CMP_IDX_STATUS, 32'h11);
    chk("event", 34'h1, {33'h0, eventOut});
    chk("irq", 34'h1, {33'h0, irqOut});
    wr(`CMP_IDX_MUX, 8'h00);
    wr(`CMP_IDX_STATUS, 8'h01);
    $display("done: invert in idle");
    sleepMode <= SLEEP_STANDBY;
    repeat (4) @(posedge ref_clk);
    chk("core", 34'h0, {32'h0, coreEn, padEn});
    wr(`CMP_IDX_CONTROL, 8'hf1);
    repeat (40) @(posedge ref_clk);
    plusAbove <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("event", 34'h1, {33'h0, eventOut});
    rd(`CMP_IDX_STATUS, 32'h00);
    perClk <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rd(`CMP_IDX_STATUS, 32'h11);
    $display("done: standby");
    sleepMode <= SLEEP_PDOWN;
    repeat (4) @(posedge ref_clk);
    chk("pdown", 34'h0, {31'h0, coreEn, padEn, eventOut});
    sleepMode <= SLEEP_ACTIVE;
    repeat (60) @(posedge ref_clk);
    $display("done: power-down");
    // With the clock enable low the result must not reach the event output.
    clkEn <= 1'b0;
    plusAbove <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk("freeze", 34'h1, {33'h0, eventOut});
    clkEn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("thaw", 34'h0, {33'h0, eventOut});
    $display("done: clock enable");
    wrapUp();
  end
endmodule
